// ===== csi_indicator.sv
/*
 * csi_indicator: red and green open-drain lamps and buzzer for status display.
 * Assumes op_state comes from logic on the same clock, and the option code
 * and thermistor come from pins (synchronised here).
 */
`timescale 1ns/100ps
module csi_indicator #(
    parameter int TICK_CYCLES = csi_pkg::CSI_TICK_CYCLES,
    parameter int FOD_PHASE_MS = csi_pkg::CSI_FOD_PHASE_MS,
    parameter int TONE_HALF_CYCLES = csi_pkg::CSI_TONE_HALF_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire csi_pkg::csi_state_t op_state,
    input wire logic [csi_pkg::CSI_OPT_W-1:0] option_code,
    input wire logic buzzer_enable,
    input wire logic [csi_pkg::CSI_PIN_COUNT-1:0] gpio_in,
    output csi_pkg::csi_pin_t [csi_pkg::CSI_PIN_COUNT-1:0] gpio_drive,
    output logic thermistor_level
);
    import csi_pkg::*;

    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam int HW = $clog2(TONE_HALF_CYCLES + 1);
    localparam int FW = $clog2(FOD_PHASE_MS + 1);
    localparam int NW = $clog2(CSI_NOTIFY_MS + 1);

    logic [TW-1:0] tick_cnt;
    logic tick;
    logic [CSI_OPT_W-1:0] opt_meta;
    logic [CSI_OPT_W-1:0] opt_sync;
    logic [CSI_OPT_W-1:0] option;
    logic opt_taken;
    logic [1:0] therm_sync;
    csi_state_t prev_state;
    logic slow_lit;
    logic fast_lit;
    logic [FW-1:0] fod_ms;
    logic fod_quiet;
    logic [NW-1:0] notify_ms;
    logic notifying;
    logic [HW-1:0] half_cnt;
    logic tone_wave;
    logic standby_on;
    logic next_red;
    logic next_green;
    logic next_buzz;
    logic tone_active;
    logic red_lit;
    logic green_lit;
    logic buzz_level;

    // one shared millisecond timebase keeps lamp and buzzer phases aligned
    always_ff @(posedge clock) begin
        if (rst) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else if (tick_cnt == TW'(TICK_CYCLES - 1)) begin
            tick_cnt <= '0;
            tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
            tick <= 1'b0;
        end
    end

    // option pins pass two flops; the code is caught once, at the first millisecond tick after reset
    always_ff @(posedge clock) begin
        if (rst) begin
            opt_meta <= CSI_OPT_RESET;
            opt_sync <= CSI_OPT_RESET;
            option <= CSI_OPT_RESET;
            opt_taken <= 1'b0;
        end else begin
            opt_meta <= option_code;
            opt_sync <= opt_meta;
            if (!opt_taken && tick) begin
                option <= opt_sync;
                opt_taken <= 1'b1;
            end
        end
    end

    // thermistor pin is only synchronised and passed on; sensing lives elsewhere
    always_ff @(posedge clock) begin
        if (rst) begin
            therm_sync <= 2'b00;
            thermistor_level <= 1'b0;
        end else begin
            therm_sync <= {therm_sync[0], gpio_in[CSI_PIN_THERM]};
            thermistor_level <= therm_sync[1];
        end
    end

    // state history for the transfer entry tone
    always_ff @(posedge clock) begin
        if (rst) begin
            prev_state <= CSI_STANDBY;
        end else begin
            prev_state <= op_state;
        end
    end

    csi_blink #(
        .ON_MS(CSI_SLOW_ON_MS),
        .OFF_MS(CSI_SLOW_OFF_MS)
    ) u_slow (
        .clock(clock),
        .rst(rst),
        .tick(tick),
        .run(op_state == CSI_TRANSFER),
        .lit(slow_lit)
    );

    csi_blink #(
        .ON_MS(CSI_FAST_ON_MS),
        .OFF_MS(CSI_FAST_OFF_MS)
    ) u_fast (
        .clock(clock),
        .rst(rst),
        .tick(tick),
        .run(op_state == CSI_FOD),
        .lit(fast_lit)
    );

    // warning buzzer alternates 30 s sounding and 30 s quiet; lamps ignore it
    always_ff @(posedge clock) begin
        if (rst || op_state != CSI_FOD) begin
            fod_ms <= '0;
            fod_quiet <= 1'b0;
        end else if (tick) begin
            if (fod_ms == FW'(FOD_PHASE_MS - 1)) begin
                fod_ms <= '0;
                fod_quiet <= !fod_quiet;
            end else begin
                fod_ms <= fod_ms + 1'b1;
            end
        end
    end

    // single 400 ms notice starting the cycle after transfer is entered
    always_ff @(posedge clock) begin
        if (rst) begin
            notify_ms <= '0;
            notifying <= 1'b0;
        end else if (op_state != CSI_TRANSFER) begin
            notify_ms <= '0;
            notifying <= 1'b0;
        end else if (prev_state != CSI_TRANSFER) begin
            notify_ms <= '0;
            notifying <= 1'b1;
        end else if (notifying && tick) begin
            if (notify_ms == NW'(CSI_NOTIFY_MS - 1)) begin
                notifying <= 1'b0;
            end else begin
                notify_ms <= notify_ms + 1'b1;
            end
        end
    end

    // 2 kHz square wave, free running; gating happens in next_buzz ahead of the output flop
    always_ff @(posedge clock) begin
        if (rst) begin
            half_cnt <= '0;
            tone_wave <= 1'b0;
        end else if (half_cnt == HW'(TONE_HALF_CYCLES - 1)) begin
            half_cnt <= '0;
            tone_wave <= !tone_wave;
        end else begin
            half_cnt <= half_cnt + 1'b1;
        end
    end

    // codes one to five light standby; code zero (nothing caught yet) and six up stay dark
    assign standby_on = (option >= CSI_OPT_PULL_DOWN)
        && (option <= CSI_OPT_LAST_ON);

    // lamp and buzzer levels per operating state
    always_comb begin
        next_red = 1'b0;
        next_green = 1'b0;
        tone_active = 1'b0;
        unique case (op_state)
            CSI_STANDBY: begin
                next_red = standby_on;
                next_green = standby_on;
            end
            CSI_TRANSFER: begin
                next_green = slow_lit;
                tone_active = notifying;
            end
            CSI_COMPLETE: begin
                next_green = 1'b1;
            end
            CSI_FAULT: begin
                next_red = 1'b1;
            end
            CSI_FOD: begin
                next_red = fast_lit;
                tone_active = fast_lit && !fod_quiet;
            end
            default: begin
                next_red = 1'b0;
            end
        endcase
        next_buzz = buzzer_enable && tone_active && tone_wave;
    end

    // registered pin levels so the outputs come straight from flops
    always_ff @(posedge clock) begin
        if (rst) begin
            red_lit <= 1'b0;
            green_lit <= 1'b0;
            buzz_level <= 1'b0;
        end else begin
            red_lit <= next_red;
            green_lit <= next_green;
            buzz_level <= next_buzz;
        end
    end

    // open drain lamps sink current when lit; buzzer is push-pull
    always_comb begin
        gpio_drive = '0;
        gpio_drive[CSI_PIN_RED].oe = red_lit;
        gpio_drive[CSI_PIN_GREEN].oe = green_lit;
        gpio_drive[CSI_PIN_BUZZ].out = buzz_level;
        gpio_drive[CSI_PIN_BUZZ].oe = 1'b1;
    end

    // first cycle of transfer on the state input
    sequence transfer_entry_s;
        op_state == CSI_TRANSFER && prev_state != CSI_TRANSFER;
    endsequence

    // buzzer and red lamp leave the same flop stage, so they are compared in one cycle
    tone_lamp_a: assert property (@(posedge clock) disable iff (rst)
        (buzz_level && $past(op_state) == CSI_FOD) |-> red_lit)
        else $error("tone not in step with red lamp");

    tone_sound_a: assert property (@(posedge clock) disable iff (rst)
        (op_state == CSI_FOD && fast_lit && !fod_quiet && buzzer_enable && tone_wave)
        |=> buzz_level)
        else $error("buzzer silent in tone phase");

    quiet_blink_a: assert property (@(posedge clock) disable iff (rst)
        (op_state == CSI_FOD && fod_quiet) |=> (!buzz_level && red_lit == $past(fast_lit)))
        else $error("warning quiet phase wrong");

    option_hold_a: assert property (@(posedge clock) disable iff (rst)
        $past(opt_taken) |-> $stable(option))
        else $error("option code changed after capture");

    green_state_a: assert property (@(posedge clock) disable iff (rst)
        (op_state == CSI_COMPLETE) |=> green_lit)
        else $error("green not lit when complete");

    red_state_a: assert property (@(posedge clock) disable iff (rst)
        (op_state == CSI_FAULT) |=> red_lit)
        else $error("red not lit in fault");

    // compare against the option as it stood when the lamps were loaded
    standby_lamp_a: assert property (@(posedge clock) disable iff (rst)
        (op_state == CSI_STANDBY) |=> (red_lit == $past(standby_on)
         && green_lit == $past(standby_on)))
        else $error("standby lamps wrong");

    notify_start_a: assert property (@(posedge clock) disable iff (rst)
        transfer_entry_s ##1 (op_state == CSI_TRANSFER) |-> notifying)
        else $error("transfer notice not started");

    tick_period_a: assert property (@(posedge clock) disable iff (rst)
        tick |=> !tick)
        else $error("tick wider than one cycle");

    fod_green_a: assert property (@(posedge clock) disable iff (rst)
        (op_state == CSI_FOD) |=> !green_lit)
        else $error("green lit during warning");
endmodule : csi_indicator

// ===== csi_pkg.sv
/*
 * csi_pkg: constants and types for the charge status indicator.
 * Assumes a 50 MHz system clock; all intervals count millisecond ticks except the tone half period, which counts clock cycles.
 */
package csi_pkg;
    localparam int CSI_CLK_HZ = 50_000_000;
    localparam int CSI_TICK_NS = 1_000_000; // one millisecond
    localparam int CSI_CLK_NS = 20;
    localparam int CSI_TICK_CYCLES = CSI_TICK_NS / CSI_CLK_NS;
    // tone half period: 2 kHz means 250 us high, 250 us low
    localparam int CSI_TONE_HZ = 2000;
    localparam int CSI_TONE_HALF_CYCLES = CSI_CLK_HZ / (2 * CSI_TONE_HZ);
    localparam int CSI_SLOW_ON_MS = 1000;
    localparam int CSI_SLOW_OFF_MS = 1000;
    localparam int CSI_FAST_ON_MS = 400;
    localparam int CSI_FAST_OFF_MS = 800;
    localparam int CSI_NOTIFY_MS = 400;
    localparam int CSI_FOD_PHASE_MS = 30_000;
    // option code field, the two pull codes, the last lit code, the last code and the reset code
    localparam int CSI_OPT_W = 4;
    localparam logic [3:0] CSI_OPT_PULL_DOWN = 4'h1;
    localparam logic [3:0] CSI_OPT_PULL_UP = 4'h6;
    localparam logic [3:0] CSI_OPT_LAST_ON = 4'h5;
    localparam logic [3:0] CSI_OPT_LAST = 4'hA;
    localparam logic [3:0] CSI_OPT_RESET = 4'h0;
    // general-purpose pin positions
    localparam int CSI_PIN_RED = 0;
    localparam int CSI_PIN_THERM = 2;
    localparam int CSI_PIN_GREEN = 3;
    localparam int CSI_PIN_BUZZ = 4;
    localparam int CSI_PIN_COUNT = 7;

    typedef enum logic [2:0] {
        CSI_STANDBY = 3'b000,
        CSI_TRANSFER = 3'b001,
        CSI_COMPLETE = 3'b010,
        CSI_FAULT = 3'b011,
        CSI_FOD = 3'b100
    } csi_state_t;

    typedef struct packed {
        logic out;
        logic oe;
    } csi_pin_t;
endpackage : csi_pkg

// ===== csi_blink.sv
/*
 * csi_blink: on/off pattern generator stepping on millisecond ticks.
 * Assumes tick is a one-cycle pulse from the shared timebase.
 */
`timescale 1ns/100ps
module csi_blink #(
    parameter int ON_MS = 1000,
    parameter int OFF_MS = 1000
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic tick,
    input wire logic run,
    output logic lit
);
    localparam int W = $clog2(ON_MS + OFF_MS + 1);
    logic [W-1:0] ms;

    // phase counter restarts while idle so each pattern begins with an on phase
    always_ff @(posedge clock) begin
        if (rst || !run) begin
            ms <= '0;
        end else if (tick) begin
            if (ms == W'(ON_MS + OFF_MS - 1)) begin
                ms <= '0;
            end else begin
                ms <= ms + 1'b1;
            end
        end
    end

    assign lit = run && (ms < W'(ON_MS));
endmodule : csi_blink

// ===== csi_lamp_model.sv
/*
 * csi_lamp_model: red and green lamps, piezo buzzer and thermistor divider
 * at the pins. Assumes every pin has a pull-up when released.
 */
`timescale 1ns/100ps
module csi_lamp_model
    import csi_pkg::*;
(
    input wire csi_pkg::csi_pin_t [csi_pkg::CSI_PIN_COUNT-1:0] gpio_drive,
    input wire logic therm_hot,
    output logic [csi_pkg::CSI_PIN_COUNT-1:0] gpio_in,
    output logic red_on,
    output logic green_on,
    output logic buzz_level
);
    // a released pin floats to its pull-up, never to the last driven value
    function automatic logic pad(input csi_pin_t p);
        return p.oe ? p.out : 1'b1;
    endfunction : pad

    // pin levels seen back at the inputs; thermistor level comes from the divider
    always_comb begin
        for (int i = 0; i < CSI_PIN_COUNT; i++) begin
            gpio_in[i] = pad(gpio_drive[i]);
        end
        gpio_in[CSI_PIN_THERM] = therm_hot;
    end

    // lamps sink current through the pin, so a low pin means lit
    assign red_on = !gpio_in[CSI_PIN_RED];
    assign green_on = !gpio_in[CSI_PIN_GREEN];
    assign buzz_level = gpio_in[CSI_PIN_BUZZ];
endmodule : csi_lamp_model

// ===== charge_status_indicator_bench.sv
/*
 * charge_status_indicator_bench: self-checking bench for csi_indicator.
 * Assumes shortened tick (10 cycles), tone half period (5 cycles) and warning
 * phase (1200 ms).
 */
`timescale 1ns/100ps
module charge_status_indicator_bench;
    import csi_pkg::*;
    localparam int TK = 10;
    localparam int PH = 1200;
    localparam int TH = 5;
    // buzzer level changes expected across one notice tone
    localparam int NT = CSI_NOTIFY_MS * TK / TH;
    typedef struct {
        csi_state_t st;
        logic th;
        logic red;
        logic green;
    } csi_row_t;
    logic clock = 1'b0;
    logic rst;
    csi_state_t op_state;
    logic [CSI_OPT_W-1:0] option_code;
    logic buzzer_enable;
    logic therm_hot;
    logic [CSI_PIN_COUNT-1:0] gpio_in;
    csi_pin_t [CSI_PIN_COUNT-1:0] gpio_drive;
    logic thermistor_level;
    logic red_on;
    logic green_on;
    logic buzz_level;
    logic red_prev;
    logic buzz_prev;
    int buzz_edges = 0;
    int tone_edges;
    csi_state_t last_state;
    int state_cycles;
    int miscompares = 0;
    int samples_checked = 0;
    csi_row_t rows[6] = '{
        '{CSI_STANDBY, 1'b1, 1'b1, 1'b1}, '{CSI_COMPLETE, 1'b0, 1'b0, 1'b1},
        '{CSI_FAULT, 1'b1, 1'b1, 1'b0}, '{CSI_STANDBY, 1'b0, 1'b1, 1'b1},
        '{CSI_TRANSFER, 1'b1, 1'b0, 1'b1}, '{CSI_FOD, 1'b0, 1'b1, 1'b0}};

    // 50 MHz system clock
    always #10 clock = ~clock;

    csi_indicator #(.TICK_CYCLES(TK), .FOD_PHASE_MS(PH), .TONE_HALF_CYCLES(TH)) DUT (
        .clock(clock), .rst(rst), .op_state(op_state), .option_code(option_code),
        .buzzer_enable(buzzer_enable), .gpio_in(gpio_in), .gpio_drive(gpio_drive),
        .thermistor_level(thermistor_level));

    csi_lamp_model lamps (.gpio_drive(gpio_drive), .therm_hot(therm_hot),
        .gpio_in(gpio_in), .red_on(red_on), .green_on(green_on), .buzz_level(buzz_level));

    task automatic check_bit(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    // walk a lamp through one period, starting lead cycles into it; margins cover tick
    // phase and output latency; ends 20 cycles into the next period
    task automatic check_pattern(input int on_ms, input int off_ms, input bit red,
            input int lead);
        repeat (on_ms * TK - 20 - lead) @(posedge clock);
        #2 check_bit("lamp late in on", 1'b1, red ? red_on : green_on);
        repeat (40) @(posedge clock);
        #2 check_bit("lamp early in off", 1'b0, red ? red_on : green_on);
        repeat (off_ms * TK - 40) @(posedge clock);
        #2 check_bit("lamp late in off", 1'b0, red ? red_on : green_on);
        repeat (40) @(posedge clock);
        #2 check_bit("lamp relit", 1'b1, red ? red_on : green_on);
    endtask : check_pattern

    task automatic enter(input csi_state_t st);
        @(posedge clock);
        #2 op_state = st;
    endtask : enter

    // cycles spent in the present state, used to place the allowed tone windows,
    // and a running count of buzzer level changes
    always @(posedge clock) begin
        red_prev <= red_on;
        buzz_prev <= buzz_level;
        buzz_edges <= (buzz_level !== buzz_prev) ? buzz_edges + 1 : buzz_edges;
        last_state <= op_state;
        state_cycles <= (op_state != last_state) ? 0 : state_cycles + 1;
    end

    // buzzer must stay low outside its windows; the cycles around a state change,
    // before the count restarts, are tolerated
    always @(negedge clock) begin
        if (!rst && buzz_level === 1'b1 && state_cycles > 2 && op_state == last_state) begin
            if (!buzzer_enable || op_state inside {CSI_STANDBY, CSI_COMPLETE, CSI_FAULT})
                check_bit("buzzer idle", 1'b0, buzz_level);
            if (op_state == CSI_TRANSFER && state_cycles > CSI_NOTIFY_MS * TK + 20)
                check_bit("notice length", 1'b0, buzz_level);
            if (op_state == CSI_FOD && !red_on && !red_prev)
                check_bit("tone with red", 1'b0, buzz_level);
            if (op_state == CSI_FOD && ((state_cycles + 15) / (PH * TK)) % 2 == 1
                    && ((state_cycles - 15) / (PH * TK)) % 2 == 1)
                check_bit("warning silence", 1'b0, buzz_level);
        end
    end

    initial begin
        rst = 1'b1;
        op_state = CSI_STANDBY;
        option_code = CSI_OPT_PULL_DOWN;
        buzzer_enable = 1'b1;
        therm_hot = 1'b0;
        repeat (2) @(posedge clock);
        #2 check_bit("buzzer oe in reset", 1'b1, gpio_drive[CSI_PIN_BUZZ].oe);
        rst = 1'b0;
        repeat (30) @(posedge clock);
        #2 option_code = CSI_OPT_PULL_UP;
        // state table; option change after capture must not matter
        foreach (rows[i]) begin
            enter(rows[i].st);
            therm_hot = rows[i].th;
            repeat (5) @(posedge clock);
            #2 check_bit("red lamp", rows[i].red, red_on);
            check_bit("green lamp", rows[i].green, green_on);
            check_bit("thermistor", rows[i].th, thermistor_level);
            check_bit("buzzer oe", 1'b1, gpio_drive[CSI_PIN_BUZZ].oe);
            check_bit("spare pins", 1'b0, |{gpio_drive[1], gpio_drive[2],
                gpio_drive[5], gpio_drive[6]});
        end
        // slow blink on transfer entry, straight from a warning, with its notice tone
        enter(CSI_TRANSFER);
        tone_edges = buzz_edges;
        check_pattern(CSI_SLOW_ON_MS, CSI_SLOW_OFF_MS, 1'b0, 0);
        tone_edges = buzz_edges - tone_edges;
        check_bit("notice tone", 1'b1, tone_edges inside {[NT - 4:NT + 3]});
        // fast blink across one tone phase and then one silent phase
        enter(CSI_FOD);
        check_pattern(CSI_FAST_ON_MS, CSI_FAST_OFF_MS, 1'b1, 0);
        check_pattern(CSI_FAST_ON_MS, CSI_FAST_OFF_MS, 1'b1, 20);
        // no buzzer fitted: transfer entry stays silent; state and enable change together
        enter(CSI_TRANSFER);
        buzzer_enable = 1'b0;
        repeat (5000) @(posedge clock);
        // fresh resets: the pull-up code keeps standby dark, code five lights it
        enter(CSI_STANDBY);
        buzzer_enable = 1'b1;
        for (int k = 0; k < 2; k++) begin
            rst = 1'b1;
            repeat (2) @(posedge clock);
            #2 rst = 1'b0;
            repeat (30) @(posedge clock);
            #2 check_bit("standby red", k == 1, red_on);
            check_bit("standby green", k == 1, green_on);
            option_code = CSI_OPT_LAST_ON;
        end
        tally_and_finish();
    end

    // cut a hang short at about twice the planned run
    initial begin
        repeat (100000) @(posedge clock);
        miscompares++;
        tally_and_finish();
    end
endmodule : charge_status_indicator_bench
